// >>> sim/testbench.sv
// self-checking bench for the core status word, table base and register access
// assumes the design package, interface and modules from src/ are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk, arst_n, sr_we, sr_flags_only, rte_restore, irq_taken, flags_we, vbr_we, insn_done;
  logic        reg_we, reg_is_addr, reg_rd_is_addr, supervisor, irq_accept, trace_req, reg_refused, busy;
  logic [1:0]  reg_size, reg_rd_size;
  logic [2:0]  irq_level, reg_idx, reg_rd_idx;
  logic [4:0]  flags_in;
  logic [7:0]  vector_num;
  logic [15:0] sr_wdata, sr_rdata;
  logic [31:0] vbr_wdata, reg_wdata, vbr_rdata, vector_addr, reg_rdata, q;
  int          n_errors, n_checks, n_trace, n_refuse, n_accept, n_busy, t0, t1;
  logic [2:0]  masks [3] = '{3'h0, 3'h3, 3'h7};

  core_state i_core_state (
    .clk(clk), .arst_n(arst_n), .sr_we(sr_we), .sr_flags_only(sr_flags_only), .sr_wdata(sr_wdata),
    .rte_restore(rte_restore), .irq_taken(irq_taken), .flags_we(flags_we), .flags_in(flags_in),
    .vbr_we(vbr_we), .vbr_wdata(vbr_wdata), .vector_num(vector_num), .irq_level(irq_level),
    .insn_done(insn_done), .reg_we(reg_we), .reg_is_addr(reg_is_addr), .reg_idx(reg_idx),
    .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rd_is_addr(reg_rd_is_addr),
    .reg_rd_idx(reg_rd_idx), .reg_rd_size(reg_rd_size), .sr_rdata(sr_rdata), .vbr_rdata(vbr_rdata),
    .vector_addr(vector_addr), .supervisor(supervisor), .irq_accept(irq_accept),
    .trace_req(trace_req), .reg_rdata(reg_rdata), .reg_refused(reg_refused), .busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one-cycle pulses are counted here so a test only looks at the totals
  always @(posedge clk) begin
    n_trace  <= n_trace + int'(trace_req === 1'b1);
    n_refuse <= n_refuse + int'(reg_refused === 1'b1);
    n_accept <= n_accept + int'(irq_accept === 1'b1);
    n_busy   <= n_busy + int'(busy === 1'b1);
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // kind 0 status write, 1 exception return, 2 interrupt taken, 3 flag update
  task automatic sr_put(input logic [15:0] d, input logic fo, input int kind);
    @(posedge clk);
    sr_wdata      <= d;
    sr_flags_only <= fo;
    flags_in      <= d[4:0];
    sr_we         <= (kind == 0);
    rte_restore   <= (kind == 1);
    irq_taken     <= (kind == 2);
    flags_we      <= (kind == 3);
    @(posedge clk);
    {sr_we, rte_restore, irq_taken, flags_we} <= 4'h0;
    idle(1);
  endtask

  task automatic rf_put(input logic a, input logic [2:0] i, input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    reg_we      <= 1'b1;
    reg_is_addr <= a;
    reg_idx     <= i;
    reg_size    <= s;
    reg_wdata   <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rf_get(input logic a, input logic [2:0] i, input logic [1:0] s);
    @(posedge clk);
    reg_rd_is_addr <= a;
    reg_rd_idx     <= i;
    reg_rd_size    <= s;
    idle(3);
    q = reg_rdata;
  endtask

  initial begin
    #100us;
    n_errors++;
    $display("watchdog expired");
    conclude();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {arst_n, sr_we, sr_flags_only, rte_restore, irq_taken, flags_we, vbr_we, insn_done} = 8'h00;
    {reg_we, reg_is_addr, reg_rd_is_addr, reg_size, reg_rd_size, reg_idx, reg_rd_idx} = 13'h0000;
    {irq_level, flags_in, vector_num, sr_wdata, vbr_wdata, reg_wdata} = 96'h0000_0000_0000_0000_0000_0000;
    idle(10);
    check("sr reset", {16'h0000, sr_rdata}, 32'h0000_2700);
    check("supervisor reset", {31'h0, supervisor}, 32'h1);
    @(posedge clk);
    arst_n <= 1'b1;
    sr_put(16'hffff, 1'b0, 0);
    check("sr full write", {16'h0000, sr_rdata}, 32'h0000_b79f);
    sr_put(16'h5a0b, 1'b1, 0);
    check("flag view", {16'h0000, sr_rdata}, 32'h0000_000b);
    @(posedge clk);
    sr_flags_only <= 1'b0;
    idle(2);
    check("sr after flag write", {16'h0000, sr_rdata}, 32'h0000_b70b);
    t0 = n_trace;
    @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
    idle(3);
    check("trace count", n_trace - t0, 32'h1);
    sr_put(16'h0015, 1'b0, 3);
    check("flag update", {16'h0000, sr_rdata}, 32'h0000_b715);
    $display("status word test done");
    @(posedge clk);
    vbr_we     <= 1'b1;
    vbr_wdata  <= 32'h1234_5678;
    vector_num <= 8'h40;
    @(posedge clk);
    vbr_we <= 1'b0;
    idle(2);
    check("vbr", vbr_rdata, 32'h1230_0000);
    check("vector addr", vector_addr, 32'h1230_0100);
    sr_put(16'h3700, 1'b0, 1);
    check("master set", {16'h0000, sr_rdata}, 32'h0000_3700);
    sr_put(16'h0000, 1'b0, 2);
    check("master clear", {16'h0000, sr_rdata}, 32'h0000_2700);
    $display("table base test done");
    foreach (masks[k]) begin
      sr_put({5'h04, masks[k], 8'h00}, 1'b0, 0);
      for (int lv = 0; lv < 7; lv++) begin
        @(posedge clk);
        irq_level <= lv[2:0];
        idle(2);
        check("irq accept", {31'h0, irq_accept}, {31'h0, (lv[2:0] > masks[k])});
      end
    end
    t0 = n_accept;
    @(posedge clk);
    irq_level <= 3'h7;
    idle(6);
    check("level 7 count", n_accept - t0, 32'h1);
    @(posedge clk);
    irq_level <= 3'h0;
    $display("interrupt mask test done");
    sr_put(16'h0005, 1'b0, 0);
    check("to user", {16'h0000, sr_rdata}, 32'h0000_0005);
    check("supervisor off", {31'h0, supervisor}, 32'h0);
    sr_put(16'hffff, 1'b0, 0);
    check("user write", {16'h0000, sr_rdata}, 32'h0000_009f);
    @(posedge clk);
    vbr_we    <= 1'b1;
    vbr_wdata <= 32'hfff0_0000;
    @(posedge clk);
    vbr_we <= 1'b0;
    idle(2);
    check("user vbr", vbr_rdata, 32'h1230_0000);
    sr_put(16'h0000, 1'b0, 2);
    check("irq to supervisor", {31'h0, supervisor}, 32'h1);
    $display("privilege test done");
    t1 = n_busy;
    rf_put(1'b0, 3'h1, core_state_pkg::SIZE_LONG, 32'hdead_beef);
    rf_get(1'b0, 3'h1, core_state_pkg::SIZE_LONG);
    check("long", q, 32'hdead_beef);
    rf_put(1'b0, 3'h1, core_state_pkg::SIZE_BYTE, 32'hffff_ff11);
    rf_get(1'b0, 3'h1, core_state_pkg::SIZE_LONG);
    check("byte merge", q, 32'hdead_be11);
    rf_put(1'b0, 3'h1, core_state_pkg::SIZE_WORD, 32'hffff_2222);
    rf_get(1'b0, 3'h1, core_state_pkg::SIZE_LONG);
    check("word merge", q, 32'hdead_2222);
    rf_get(1'b0, 3'h1, core_state_pkg::SIZE_BYTE);
    check("byte read", q, 32'h0000_0022);
    rf_put(1'b1, 3'h3, core_state_pkg::SIZE_WORD, 32'h0000_8001);
    rf_get(1'b1, 3'h3, core_state_pkg::SIZE_LONG);
    check("addr word", q, 32'hffff_8001);
    t0 = n_refuse;
    rf_put(1'b1, 3'h3, core_state_pkg::SIZE_BYTE, 32'h0000_0055);
    idle(4);
    check("refused count", n_refuse - t0, 32'h1);
    rf_get(1'b1, 3'h3, core_state_pkg::SIZE_LONG);
    check("addr kept", q, 32'hffff_8001);
    check("busy cycles", n_busy - t1, 32'h5);
    $display("register test done");
    @(posedge clk);
    arst_n <= 1'b0;
    idle(2);
    check("sr second reset", {16'h0000, sr_rdata}, 32'h0000_2700);
    @(posedge clk);
    arst_n <= 1'b1;
    idle(2);
    check("sr after release", {16'h0000, sr_rdata}, 32'h0000_2700);
    check("supervisor after release", {31'h0, supervisor}, 32'h1);
    check("vbr after release", vbr_rdata, 32'h0000_0000);
    $display("second reset test done");
    conclude();
  end
endmodule // testbench

// >>> src/core_regfile.sv
// eight data and eight address registers with sized write merge
// assumes one write port and one read port per cycle on the core clock
module core_regfile (
  input  wire logic clk,
  input  wire logic arst_n,
  regfile_if.file   rf
);

  logic [31:0] dreg_q [8];
  logic [31:0] areg_q [8];
  logic [31:0] dreg_d [8];
  logic [31:0] areg_d [8];
  logic [31:0] rd_d;
  logic        ref_d;

  // ****************************************
  // sized merge
  // ****************************************
  function automatic logic [31:0] merge_data(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [1:0] sz);
    if (sz == core_state_pkg::SIZE_BYTE) begin
      merge_data = {old[31:8], nw[7:0]};  // [RULE_12] [RULE_13]
    end else if (sz == core_state_pkg::SIZE_WORD) begin
      merge_data = {old[31:16], nw[15:0]};  // [RULE_12]
    end else begin
      merge_data = nw;  // [RULE_11]
    end
  endfunction

  always_comb begin
    dreg_d = dreg_q;
    areg_d = areg_q;
    ref_d  = 1'b0;
    if (rf.we && !rf.addr_reg) begin
      dreg_d[rf.idx] = merge_data(dreg_q[rf.idx], rf.wdata, rf.size);
    end else if (rf.we && rf.size == core_state_pkg::SIZE_BYTE) begin
      ref_d = 1'b1;  // [RULE_14]
    end else if (rf.we && rf.size == core_state_pkg::SIZE_WORD) begin
      areg_d[rf.idx] = {{16{rf.wdata[15]}}, rf.wdata[15:0]};  // [RULE_15] [RULE_16]
    end else if (rf.we) begin
      areg_d[rf.idx] = rf.wdata;  // [RULE_16]
    end
    rd_d = rf.raddr_reg ? areg_d[rf.ridx] : dreg_d[rf.ridx];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        dreg_q[i] <= 32'h0000_0000;
        areg_q[i] <= 32'h0000_0000;
      end
      rf.rdata   <= 32'h0000_0000;
      rf.refused <= 1'b0;
    end else begin
      dreg_q     <= dreg_d;
      areg_q     <= areg_d;
      rf.rdata   <= rd_d;
      rf.refused <= ref_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_byte_keeps_upper;
    @(posedge clk) disable iff (!arst_n)
      (rf.we && !rf.addr_reg && rf.size == core_state_pkg::SIZE_BYTE)
      |=> dreg_q[$past(rf.idx)][31:8] == $past(dreg_q[rf.idx][31:8]);
  endproperty
  a_byte_keeps_upper: assert property (p_byte_keeps_upper) else $error("byte write touched upper bits"); // [RULE_12]

  property p_word_sext;
    @(posedge clk) disable iff (!arst_n)
      (rf.we && rf.addr_reg && rf.size == core_state_pkg::SIZE_WORD)
      |=> areg_q[$past(rf.idx)][31:16] == {16{$past(rf.wdata[15])}};
  endproperty
  a_word_sext: assert property (p_word_sext) else $error("address word write not sign extended"); // [RULE_15]

  property p_byte_refused;
    @(posedge clk) disable iff (!arst_n)
      (rf.we && rf.addr_reg && rf.size == core_state_pkg::SIZE_BYTE)
      |=> rf.refused && areg_q[$past(rf.idx)] == $past(areg_q[rf.idx]);
  endproperty
  a_byte_refused: assert property (p_byte_refused) else $error("address byte write not refused"); // [RULE_14]

endmodule : core_regfile

// >>> src/core_state.sv
// status word, exception table base, interrupt gating and register access
// assumes the sequencer presents one operation per cycle as plain requests
module core_state (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        sr_we,
  input  wire logic        sr_flags_only,
  input  wire logic [15:0] sr_wdata,
  input  wire logic        rte_restore,
  input  wire logic        irq_taken,
  input  wire logic        flags_we,
  input  wire logic [4:0]  flags_in,
  input  wire logic        vbr_we,
  input  wire logic [31:0] vbr_wdata,
  input  wire logic [7:0]  vector_num,
  input  wire logic [2:0]  irq_level,
  input  wire logic        insn_done,
  input  wire logic        reg_we,
  input  wire logic        reg_is_addr,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [1:0]  reg_size,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd_is_addr,
  input  wire logic [2:0]  reg_rd_idx,
  input  wire logic [1:0]  reg_rd_size,
  output logic      [15:0] sr_rdata,
  output logic      [31:0] vbr_rdata,
  output logic      [31:0] vector_addr,
  output logic             supervisor,
  output logic             irq_accept,
  output logic             trace_req,
  output logic      [31:0] reg_rdata,
  output logic             reg_refused,
  output logic             busy
);

  regfile_if rf ();

  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic [31:0] vbr_q;
  logic [31:0] vbr_d;
  logic [15:0] srr_d;
  logic [31:0] vaddr_d;
  logic        irq_d;
  logic        trace_d;
  logic [2:0]  lvl7_q;
  logic [2:0]  lvl7_d;
  logic        nmi_edge;
  logic [1:0]  rd_size_q;
  logic        rd_addr_q;
  logic [31:0] rdat_d;
  logic [31:0] rdat_q;
  logic        refd_q;
  core_state_pkg::wr_state_e st_q;
  core_state_pkg::wr_state_e st_d;

  // ****************************************
  // status word
  // ****************************************
  function automatic logic [15:0] sr_merge(input logic [15:0] old, input logic [15:0] nw, input logic sup);
    logic [15:0] m;
    m = sup ? core_state_pkg::SR_WRITABLE : core_state_pkg::SR_USER_MASK;  // [RULE_01]
    sr_merge = ((old & ~m) | (nw & m)) & core_state_pkg::SR_WRITABLE;  // [RULE_07] [RULE_18]
  endfunction

  always_comb begin
    sr_d = sr_q;
    if (sr_we && sr_flags_only) begin
      sr_d = sr_merge(sr_q, {8'h00, sr_wdata[7:0]}, 1'b0);  // [RULE_17]
    end else if (sr_we || rte_restore) begin
      sr_d = sr_merge(sr_q, sr_wdata, sr_q[core_state_pkg::SUPER_BIT] | rte_restore);  // [RULE_05]
    end else if (flags_we) begin
      sr_d = {sr_q[15:5], flags_in};
    end
    if (irq_taken) begin
      sr_d[core_state_pkg::MASTER_BIT] = 1'b0;  // [RULE_05]
      sr_d[core_state_pkg::SUPER_BIT]  = 1'b1;
    end
    // flag-only reads see a zero upper byte
    srr_d = sr_flags_only ? {8'h00, sr_d[7:0]} : sr_d;  // [RULE_17]
  end

  // ****************************************
  // exception table base and vector address
  // ****************************************
  always_comb begin
    vbr_d = vbr_q;
    if (vbr_we && sr_q[core_state_pkg::SUPER_BIT]) begin
      vbr_d = vbr_wdata & core_state_pkg::VBR_KEEP_MASK;  // [RULE_08]
    end
    // displacement is four bytes per vector
    vaddr_d = vbr_d + {22'h00_0000, vector_num, 2'b00};  // [RULE_09]
  end

  // ****************************************
  // interrupt gating and trace
  // ****************************************
  // level 7 is edge sensitive: a held level 7 is accepted once
  assign nmi_edge = (lvl7_q[2:1] == 2'b01);

  always_comb begin
    lvl7_d = {lvl7_q[1:0], irq_level == core_state_pkg::LEVEL_NMI};
    irq_d  = nmi_edge ||
             (irq_level != core_state_pkg::LEVEL_NMI &&
              irq_level > sr_q[core_state_pkg::MASK_LSB +: 3]);  // [RULE_06]
    trace_d = insn_done && sr_q[core_state_pkg::TRACE_BIT];  // [RULE_03]
  end

  // ****************************************
  // register file access
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      core_state_pkg::WR_IDLE: begin
        if (reg_we) begin
          st_d = core_state_pkg::WR_BUSY;
        end
      end
      core_state_pkg::WR_BUSY: begin
        if (!reg_we) begin
          st_d = core_state_pkg::WR_IDLE;
        end
      end
      default: st_d = core_state_pkg::WR_IDLE;
    endcase
  end

  assign rf.we        = reg_we;
  assign rf.addr_reg  = reg_is_addr;
  assign rf.idx       = reg_idx;
  assign rf.size      = reg_size;
  assign rf.wdata     = reg_wdata;
  assign rf.ridx      = reg_rd_idx;
  assign rf.raddr_reg = reg_rd_is_addr;

  core_regfile u_regfile (
    .clk    (clk),
    .arst_n (arst_n),
    .rf     (rf)
  );

  // sized source view of the file read
  always_comb begin
    if (rd_size_q == core_state_pkg::SIZE_BYTE) begin
      rdat_d = {24'h00_0000, rf.rdata[7:0]};  // [RULE_12]
    end else if (rd_size_q == core_state_pkg::SIZE_WORD && rd_addr_q) begin
      rdat_d = {{16{rf.rdata[15]}}, rf.rdata[15:0]};  // [RULE_15]
    end else if (rd_size_q == core_state_pkg::SIZE_WORD) begin
      rdat_d = {16'h0000, rf.rdata[15:0]};
    end else begin
      rdat_d = rf.rdata;  // [RULE_11]
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q        <= {core_state_pkg::SR_RESET_HI, 8'h00};  // [RULE_02]
      vbr_q       <= 32'h0000_0000;
      sr_rdata    <= {core_state_pkg::SR_RESET_HI, 8'h00};
      vbr_rdata   <= 32'h0000_0000;
      vector_addr <= 32'h0000_0000;
      supervisor  <= 1'b1;
      irq_accept  <= 1'b0;
      trace_req   <= 1'b0;
      lvl7_q      <= 3'h0;
      rd_size_q   <= core_state_pkg::SIZE_LONG;
      rd_addr_q   <= 1'b0;
      rdat_q      <= 32'h0000_0000;
      refd_q      <= 1'b0;
      st_q        <= core_state_pkg::WR_IDLE;
      busy        <= 1'b0;
    end else begin
      sr_q        <= sr_d;
      vbr_q       <= vbr_d;
      sr_rdata    <= srr_d;
      vbr_rdata   <= vbr_d;
      vector_addr <= vaddr_d;
      supervisor  <= sr_d[core_state_pkg::SUPER_BIT];  // [RULE_04]
      irq_accept  <= irq_d;
      trace_req   <= trace_d;
      lvl7_q      <= lvl7_d;
      rd_size_q   <= reg_rd_size;
      rd_addr_q   <= reg_rd_is_addr;
      rdat_q      <= rdat_d;
      refd_q      <= rf.refused;
      st_q        <= st_d;
      busy        <= (st_d == core_state_pkg::WR_BUSY);
    end
  end

  assign reg_rdata   = rdat_q;
  assign reg_refused = refd_q;

  // ****************************************
  // checks
  // ****************************************
  property p_user_keeps_upper;
    @(posedge clk) disable iff (!arst_n)
      (sr_we && !sr_q[13] && !rte_restore && !irq_taken) |=> sr_q[15:8] == $past(sr_q[15:8]);
  endproperty
  a_user_keeps_upper: assert property (p_user_keeps_upper) else $error("user write changed system byte"); // [RULE_01]

  property p_reserved_zero;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |-> (sr_rdata & ~core_state_pkg::SR_WRITABLE) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set"); // [RULE_07]

  property p_irq_master;
    @(posedge clk) disable iff (!arst_n)
      irq_taken |=> !sr_q[12] && supervisor;
  endproperty
  a_irq_master: assert property (p_irq_master) else $error("master bit not cleared by interrupt"); // [RULE_05]

  property p_trace;
    @(posedge clk) disable iff (!arst_n)
      insn_done |=> trace_req == $past(sr_q[15]);
  endproperty
  a_trace: assert property (p_trace) else $error("trace request wrong"); // [RULE_03]

  property p_mask;
    @(posedge clk) disable iff (!arst_n)
      (!nmi_edge && irq_level != 3'h7 && irq_level <= sr_q[10:8]) |=> !irq_accept;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt accepted"); // [RULE_06]

  property p_vbr_low;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |-> vbr_rdata[19:0] == 20'h0_0000;
  endproperty
  a_vbr_low: assert property (p_vbr_low) else $error("table base low bits nonzero"); // [RULE_08]

  property p_vec_addr;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> vector_addr == vbr_q + {22'h00_0000, $past(vector_num), 2'b00};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // [RULE_09]

  property p_super_flag;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |-> supervisor == sr_q[13];
  endproperty
  a_super_flag: assert property (p_super_flag) else $error("supervisor output mismatch"); // [RULE_04]

  property p_flags_upper;
    @(posedge clk) disable iff (!arst_n)
      (sr_we && sr_flags_only) |=> sr_rdata[15:8] == 8'h00;
  endproperty
  a_flags_upper: assert property (p_flags_upper) else $error("flag read upper byte nonzero"); // [RULE_17]

  property p_super_write;
    @(posedge clk) disable iff (!arst_n)
      (sr_we && !sr_flags_only && sr_q[13] && !irq_taken) |=> sr_q == ($past(sr_wdata) & core_state_pkg::SR_WRITABLE);
  endproperty
  a_super_write: assert property (p_super_write) else $error("supervisor write not taken whole"); // [RULE_01]

  property p_user_vbr;
    @(posedge clk) disable iff (!arst_n)
      (vbr_we && !sr_q[13]) |=> vbr_q == $past(vbr_q);
  endproperty
  a_user_vbr: assert property (p_user_vbr) else $error("user mode changed table base"); // [RULE_01]

  property p_vbr_write;
    @(posedge clk) disable iff (!arst_n)
      (vbr_we && sr_q[13]) |=> vbr_q == ($past(vbr_wdata) & core_state_pkg::VBR_KEEP_MASK);
  endproperty
  a_vbr_write: assert property (p_vbr_write) else $error("table base write wrong"); // [RULE_08]

  property p_trace_off;
    @(posedge clk) disable iff (!arst_n)
      !sr_q[15] |=> !trace_req;
  endproperty
  a_trace_off: assert property (p_trace_off) else $error("trace request with trace off"); // [RULE_03]

  property p_rte_master;
    @(posedge clk) disable iff (!arst_n)
      (rte_restore && !sr_we && !irq_taken) |=> sr_q[12] == $past(sr_wdata[12]);
  endproperty
  a_rte_master: assert property (p_rte_master) else $error("return did not restore master bit"); // [RULE_05]

  property p_unmasked;
    @(posedge clk) disable iff (!arst_n)
      (irq_level != 3'h7 && irq_level > sr_q[10:8]) |=> irq_accept;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked interrupt not accepted"); // [RULE_06]

  property p_nmi_edge;
    @(posedge clk) disable iff (!arst_n)
      nmi_edge |=> irq_accept;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("level 7 edge not accepted"); // [RULE_06]

  property p_flags_update;
    @(posedge clk) disable iff (!arst_n)
      (flags_we && !sr_we && !rte_restore && !irq_taken) |=> sr_q[4:0] == $past(flags_in);
  endproperty
  a_flags_update: assert property (p_flags_update) else $error("flag update lost"); // [RULE_18]

  property p_flag_write_keeps_sys;
    @(posedge clk) disable iff (!arst_n)
      (sr_we && sr_flags_only && !irq_taken) |=> sr_q[15:8] == $past(sr_q[15:8]);
  endproperty
  a_flag_write_keeps_sys: assert property (p_flag_write_keeps_sys) else $error("flag write changed system byte"); // [RULE_17]

endmodule : core_state

// >>> src/core_state_pkg.sv
// constants for the core status word, exception table base and register file
// assumes a single core clock and one asynchronous active-low reset
//
// Notes on behaviour
// [RULE_01] supervisor writes whole status word; user low byte
// [RULE_02] reset loads upper byte 0x27: supervisor, mask 111
// [RULE_03] trace bit 15 requests trace after each instruction
// [RULE_04] bit 13 shows privilege: one is supervisor
// [RULE_05] interrupt clears master bit; software may set
// [RULE_06] mask blocks levels at or below; level 7 passes
// [RULE_07] reserved bits always read zero
// [RULE_08] table base low twenty bits unstored, read zero
// [RULE_09] vector address is base plus displacement
// [RULE_10] software aligns onchip ram base to 32 Kbyte
// [RULE_11] data registers are 32 bits, longwords use all
// [RULE_12] byte or word writes keep upper bits
// [RULE_13] bit zero is the least significant bit
// [RULE_14] byte size refused for address registers
// [RULE_15] word source sign-extended for address destination
// [RULE_16] address register writes update all bits
// [RULE_17] flag-only access: upper byte zero, writes dropped
// [RULE_18] low byte: hint bit 7, flags 4 to 0
package core_state_pkg;

  // ****************************************
  // status word layout
  // ****************************************
  localparam int TRACE_BIT      = 15;
  localparam int SUPER_BIT      = 13;
  localparam int MASTER_BIT     = 12;
  localparam int MASK_LSB       = 8;
  localparam int HINT_BIT       = 7;
  localparam logic [15:0] SR_WRITABLE  = 16'hb79f;
  localparam logic [15:0] SR_USER_MASK = 16'h009f;
  localparam logic [7:0]  SR_RESET_HI  = 8'h27;
  localparam logic [2:0]  LEVEL_NMI    = 3'h7;

  // ****************************************
  // exception table base
  // ****************************************
  localparam logic [31:0] VBR_KEEP_MASK = 32'hfff0_0000;

  // ****************************************
  // operand sizes
  // ****************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // ****************************************
  // onchip ram base alignment, kept by software
  // ****************************************
  localparam logic [31:0] RAM_ALIGN_MASK = 32'h0000_7fff;

  // ****************************************
  // register file write state
  // ****************************************
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_BUSY = 2'b10
  } wr_state_e;

endpackage : core_state_pkg

// >>> src/regfile_if.sv
// signals between the state block and its register file
// assumes both ends run on the same core clock
interface regfile_if;
  logic        we;
  logic        addr_reg;
  logic [2:0]  idx;
  logic [1:0]  size;
  logic [31:0] wdata;
  logic [2:0]  ridx;
  logic        raddr_reg;
  logic [31:0] rdata;
  logic        refused;
  modport ctrl (output we, addr_reg, idx, size, wdata, ridx, raddr_reg, input rdata, refused);
  modport file (input we, addr_reg, idx, size, wdata, ridx, raddr_reg, output rdata, refused);
endinterface : regfile_if
